// file: logic/net_host_pins_map.vh
// constants for the network module host pin and status glue
// assumes a 40 MHz clock on clk_i
`ifndef NET_HOST_PINS_MAP_VH
`define NET_HOST_PINS_MAP_VH
`define MODE_CLOCKED     2'h0
`define MODE_EXT_CLOCKED 2'h1
`define MODE_NON_CLOCKED 2'h2
`define MODE_I2C         2'h3
`define CLK_MHZ          40
`define CTRL_RST_MIN_US  10
`define CTRL_RST_CYCLES  (`CTRL_RST_MIN_US * `CLK_MHZ)
`define PHY_RST_MIN_MS   10
`define PHY_RST_CYCLES   (`PHY_RST_MIN_MS * 1000 * `CLK_MHZ)
`define BLINK_HALF_MS    50
`define BLINK_HALF_CYCLES (`BLINK_HALF_MS * 1000 * `CLK_MHZ)
`define IRQ_BITS         8
`define ADDR_BITS        15
`define DATA_BITS        8
`define I2C_ADDR_LSB     8
`define CNT_BITS         24
`endif

// file: logic/min_pulse_check.v
// counts how long an active-low reset level has been held
// assumes the level is synchronous to clk_i
`timescale 1ns/100ps
`include "net_host_pins_map.vh"
module min_pulse_check #(
  parameter [23:0] MIN_CYCLES = 24'h000190
) (
  input  wire       clk_i,
  input  wire       nrst_i,
  input  wire       en_i,
  input  wire       level_n_i,
  output reg        done_o
);
  reg [23:0] cnt;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt    <= 24'h000000;
      done_o <= 1'b0;
    end else if (en_i) begin
      if (level_n_i) begin
        cnt <= 24'h000000;
      end else if (cnt != MIN_CYCLES) begin
        cnt <= cnt + 24'h000001;
      end
      done_o <= !level_n_i && (cnt == MIN_CYCLES);
    end
  end
endmodule // min_pulse_check

// file: logic/net_host_pins.v
// host pin glue and network status indicators of the network module
// assumes every input but host_side_clock_in_i and the async nrst_i synchronous to clk_i; controller core sits outside
`timescale 1ns/100ps
`include "net_host_pins_map.vh"
module net_host_pins #(
  parameter [23:0] CTRL_RST_CYCLES   = `CTRL_RST_CYCLES,
  parameter [23:0] PHY_RST_CYCLES    = `PHY_RST_CYCLES,
  parameter [23:0] BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
) (
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        ce_i,
  input  wire [1:0]  host_if_strap_i,
  input  wire        host_side_clock_in_i,
  input  wire [14:0] addr_i,
  input  wire [7:0]  data_i,
  input  wire        select_n_i,
  input  wire        read_n_i,
  input  wire        write_n_i,
  input  wire        ctrl_reset_n_i,
  input  wire        phy_reset_n_i,
  input  wire [7:0]  irq_event_i,
  input  wire        irq_status_wr_i,
  input  wire        irq_mask_wr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        collision_i,
  input  wire        link_up_i,
  input  wire        speed_100_i,
  input  wire        full_duplex_i,
  input  wire        traffic_i,
  output reg  [1:0]  host_if_mode_o,
  output reg         ext_clock_sel_o,
  output reg  [14:0] bus_addr_o,
  output reg  [6:0]  i2c_dev_addr_o,
  output reg  [7:0]  data_o,
  output reg         data_oe_o,
  output reg         bus_read_o,
  output reg         bus_write_o,
  output reg         host_clk_sample_o,
  output reg  [7:0]  irq_status_o,
  output reg  [7:0]  irq_mask_reg_o,
  output reg         int_n_o,
  output reg         collision_led_n_o,
  output reg         fast_link_activity_led_n_o,
  output reg         slow_link_activity_led_n_o,
  output reg         duplex_led_n_o,
  output reg         link_led_n_o,
  output reg         ctrl_in_reset_o,
  output reg         phy_ready_o
);
  wire       ctrl_rst_done;
  wire       phy_rst_done;
  reg  [1:0] mode;
  reg  [1:0] host_clk_sync;
  reg  [23:0] blink_cnt;
  reg        blink;
  reg        act_hold;
  reg  [7:0] next_status;
  wire       bus_mode;
  wire       blink_led;

  min_pulse_check #(.MIN_CYCLES(CTRL_RST_CYCLES)) u_ctrl_rst (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .en_i      (ce_i),
    .level_n_i (ctrl_reset_n_i),
    .done_o    (ctrl_rst_done)
  );

  min_pulse_check #(.MIN_CYCLES(PHY_RST_CYCLES)) u_phy_rst (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .en_i      (ce_i),
    .level_n_i (phy_reset_n_i),
    .done_o    (phy_rst_done)
  );

  assign bus_mode  = (mode != `MODE_I2C);
  // activity blink gated by act_hold: dark phase only while traffic seen
  assign blink_led = act_hold ? blink : 1'b0;

  // set wins over the host clear of the same bit
  always @* begin
    next_status = irq_status_o;
    if (irq_status_wr_i) begin
      next_status = next_status & ~reg_wdata_i;
    end
    next_status = next_status | irq_event_i;
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode                       <= `MODE_CLOCKED;
      host_if_mode_o             <= `MODE_CLOCKED;
      ext_clock_sel_o            <= 1'b0;
      bus_addr_o                 <= 15'h0000;
      i2c_dev_addr_o             <= 7'h00;
      data_o                     <= 8'h00;
      data_oe_o                  <= 1'b0;
      bus_read_o                 <= 1'b0;
      bus_write_o                <= 1'b0;
      host_clk_sync              <= 2'h0;
      host_clk_sample_o          <= 1'b0;
      irq_status_o               <= 8'h00;
      irq_mask_reg_o             <= 8'h00;
      int_n_o                    <= 1'b1;
      collision_led_n_o          <= 1'b1;
      fast_link_activity_led_n_o <= 1'b1;
      slow_link_activity_led_n_o <= 1'b1;
      duplex_led_n_o             <= 1'b1;
      link_led_n_o               <= 1'b1;
      blink_cnt                  <= 24'h000000;
      blink                      <= 1'b0;
      act_hold                   <= 1'b0;
      ctrl_in_reset_o            <= 1'b0;
      phy_ready_o                <= 1'b0;
    end else if (ce_i) begin
      ctrl_in_reset_o <= !ctrl_reset_n_i;
      phy_ready_o     <= phy_reset_n_i ? (phy_ready_o | phy_rst_done) : phy_rst_done;
      if (ctrl_rst_done) begin
        // straps resampled at every qualified reset; open pins read zero
        mode            <= host_if_strap_i;
        host_if_mode_o  <= host_if_strap_i;
        ext_clock_sel_o <= (host_if_strap_i == `MODE_EXT_CLOCKED);
        irq_status_o    <= 8'h00;
        irq_mask_reg_o  <= 8'h00;
        int_n_o         <= 1'b1;
        data_oe_o       <= 1'b0;
        bus_read_o      <= 1'b0;
        bus_write_o     <= 1'b0;
      end else begin
        irq_status_o <= next_status;
        if (irq_mask_wr_i) begin
          irq_mask_reg_o <= reg_wdata_i;
        end
        // same-edge mask load counts, so the pin never lags the mask it shows
        int_n_o <= ~|(next_status & (irq_mask_wr_i ? reg_wdata_i : irq_mask_reg_o));
        // strobes taken active low, only in bus modes
        bus_read_o  <= bus_mode && !select_n_i && !read_n_i;
        bus_write_o <= bus_mode && !select_n_i && !write_n_i && read_n_i;
        data_oe_o   <= bus_mode && !select_n_i && !read_n_i;
        if (bus_mode && !select_n_i && !write_n_i) begin
          data_o <= data_i;
        end
        if (bus_mode) begin
          bus_addr_o <= addr_i;
        end else begin
          i2c_dev_addr_o <= addr_i[14:`I2C_ADDR_LSB];
        end
      end
      // two flops; only the second one is used
      host_clk_sync     <= {host_clk_sync[0], host_side_clock_in_i};
      host_clk_sample_o <= ext_clock_sel_o ? host_clk_sync[1] : 1'b0;
      // fixed half period keeps the blink visible whatever the traffic
      if (blink_cnt >= BLINK_HALF_CYCLES - 24'h000001) begin
        blink_cnt <= 24'h000000;
        blink     <= ~blink;
        act_hold  <= traffic_i;
      end else begin
        blink_cnt <= blink_cnt + 24'h000001;
        if (traffic_i) begin
          act_hold <= 1'b1;
        end
      end
      collision_led_n_o          <= ~collision_i;
      fast_link_activity_led_n_o <= ~(link_up_i && speed_100_i) | blink_led;
      slow_link_activity_led_n_o <= ~(link_up_i && !speed_100_i) | blink_led;
      duplex_led_n_o             <= ~full_duplex_i;
      link_led_n_o               <= ~link_up_i;
    end
  end
endmodule // net_host_pins

// file: bench/host_model.sv
// host side strobe driver for the pin glue
// assumes rd_i and wr_i are set by the bench just after an edge
`timescale 1ns/100ps
module host_model (
  input  wire  clk_i,
  input  wire  rd_i,
  input  wire  wr_i,
  output logic select_n_o = 1'b1,
  output logic read_n_o   = 1'b1,
  output logic write_n_o  = 1'b1
);
  // strobes change just after the edge and stand a whole cycle
  always @(posedge clk_i) begin
    select_n_o <= #1 !(rd_i | wr_i);
    read_n_o   <= #1 !rd_i;
    write_n_o  <= #1 !wr_i;
  end
endmodule // host_model

// file: bench/net_host_pins_properties.sv
// port assertions for the host pin glue
// assumes one clock clk_i and async active-low nrst_i
`timescale 1ns/100ps
module net_host_pins_properties (
  input logic        clk_i, nrst_i, ce_i, ctrl_reset_n_i,
  input logic        select_n_i, read_n_i, link_up_i,
  input logic        collision_i, full_duplex_i,
  input logic [14:0] addr_i,
  input logic [7:0]  irq_event_i, irq_status_o, irq_mask_reg_o,
  input logic [1:0]  host_if_mode_o,
  input logic [6:0]  i2c_dev_addr_o,
  input logic        int_n_o, bus_read_o, link_led_n_o, ctrl_in_reset_o,
  input logic        collision_led_n_o, duplex_led_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_link_led_level: assert property (ce_i |=> link_led_n_o == !$past(link_up_i))
    else $error("link led wrong");
  a_col_led_level: assert property (ce_i |=> collision_led_n_o == !$past(collision_i))
    else $error("collision led wrong");
  a_dup_led_level: assert property (ce_i |=> duplex_led_n_o == !$past(full_duplex_i))
    else $error("duplex led wrong");
  a_int_from_mask: assert property (int_n_o == !(|(irq_status_o & irq_mask_reg_o)))
    else $error("interrupt pin wrong");
  a_irq_sets_status: assert property (ce_i && ctrl_reset_n_i && !ctrl_in_reset_o && |irq_event_i
    |=> (irq_status_o & $past(irq_event_i)) == $past(irq_event_i)) else $error("status not set");
  a_read_decoded: assert property (ce_i && !ctrl_in_reset_o && host_if_mode_o != 2'h3 && !select_n_i && !read_n_i
    |=> bus_read_o) else $error("read not seen");
  a_i2c_dev_addr: assert property (ce_i && !ctrl_in_reset_o && host_if_mode_o == 2'h3
    |=> {i2c_dev_addr_o, 8'h00} == ($past(addr_i) & 15'h7f00)) else $error("i2c address wrong");
  a_mode_in_reset: assert property ($changed(host_if_mode_o) |-> !$past(ctrl_reset_n_i))
    else $error("mode moved outside reset");
endmodule // net_host_pins_properties
bind net_host_pins net_host_pins_properties i_props (.*);

// file: bench/net_host_pins_test.sv
// self-checking bench for the host pin glue
// assumes host_model drives strobes, the bench the rest
`timescale 1ns/100ps
module net_host_pins_test;
  localparam int CR = 400, PR = 20, BH = 8;
  logic clk_i = 0, nrst_i = 0, ce_i = 1, host_side_clock_in_i = 0, rd = 0, wr = 0;
  logic select_n_i, read_n_i, write_n_i, ctrl_reset_n_i = 1, phy_reset_n_i = 1;
  logic irq_status_wr_i = 0, irq_mask_wr_i = 0, collision_i = 0, link_up_i = 0;
  logic speed_100_i = 0, full_duplex_i = 0, traffic_i = 0;
  logic [1:0]  host_if_strap_i = 0, host_if_mode_o;
  logic [14:0] addr_i = 15'h5a3c, bus_addr_o;
  logic [7:0]  data_i = 8'h96, reg_wdata_i = 0, irq_event_i = 0, data_o, irq_status_o, irq_mask_reg_o;
  logic [6:0]  i2c_dev_addr_o;
  logic ext_clock_sel_o, data_oe_o, bus_read_o, bus_write_o, host_clk_sample_o, int_n_o;
  logic collision_led_n_o, fast_link_activity_led_n_o, slow_link_activity_led_n_o;
  logic duplex_led_n_o, link_led_n_o, ctrl_in_reset_o, phy_ready_o;
  int n_mismatch = 0, compares = 0, hi, lo;
  // link speed duplex collision, then link fast slow duplex collision leds
  logic [8:0] rows [5] = '{9'h01f, 9'h1c5, 9'h12a, 9'h09f, 9'h07c};
  initial forever #12.5 clk_i = ~clk_i;
  net_host_pins #(.CTRL_RST_CYCLES(24'd400), .PHY_RST_CYCLES(24'd20), .BLINK_HALF_CYCLES(24'd8))
    i_net_host_pins (.*);
  host_model i_host_model (.clk_i, .rd_i(rd), .wr_i(wr), .select_n_o(select_n_i),
    .read_n_o(read_n_i), .write_n_o(write_n_i));
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200us;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    step(3);
    chk("reset", 15'h78, {int_n_o, link_led_n_o, duplex_led_n_o, collision_led_n_o, ext_clock_sel_o, host_if_mode_o});
    nrst_i = 1;
    foreach (rows[i]) begin
      {link_up_i, speed_100_i, full_duplex_i, collision_i} = rows[i][8:5];
      step(1);
      chk("leds", rows[i][4:0], {link_led_n_o, fast_link_activity_led_n_o, slow_link_activity_led_n_o,
        duplex_led_n_o, collision_led_n_o});
    end
    $display("led table done");
    reg_wdata_i = 8'h01;
    irq_mask_wr_i = 1;
    step(1);
    irq_mask_wr_i = 0;
    irq_event_i = 8'h03;
    step(1);
    irq_event_i = 0;
    chk("irq set", 15'h006, {irq_status_o, int_n_o});
    irq_status_wr_i = 1;
    step(1);
    irq_status_wr_i = 0;
    chk("irq clear", 15'h005, {irq_status_o, int_n_o});
    $display("interrupt test done");
    rd = 1;
    step(2);
    chk("read", {addr_i[12:0], 2'h3}, {bus_addr_o[12:0], bus_read_o, data_oe_o});
    rd = 0;
    wr = 1;
    step(2);
    chk("write", {data_i, 1'b1}, {data_o, bus_write_o});
    wr = 0;
    $display("bus test done");
    for (int s = 0; s < 2; s++) begin
      {link_up_i, speed_100_i, traffic_i} = {1'b1, s[0], 1'b1};
      hi = 0;
      lo = 0;
      repeat (8 * BH) begin
        step(1);
        if ((s ? fast_link_activity_led_n_o : slow_link_activity_led_n_o) === 1'b1) hi++;
        else lo++;
      end
      chk("blink", 1, hi > 0 && lo > 0);
    end
    traffic_i = 0;
    $display("blink test done");
    for (int m = 0; m < 4; m++) begin
      host_if_strap_i = m[1:0];
      ctrl_reset_n_i = 0;
      step(CR + 3);
      chk("in reset", 1, ctrl_in_reset_o);
      ctrl_reset_n_i = 1;
      step(1);
      chk("out of reset", 0, ctrl_in_reset_o);
      chk("mode", {m[1:0], m == 1}, {host_if_mode_o, ext_clock_sel_o});
      host_side_clock_in_i = 1;
      step(4);
      chk("ext clock", m == 1, host_clk_sample_o);
      host_side_clock_in_i = 0;
    end
    chk("status cleared", 0, irq_status_o);
    chk("i2c addr", addr_i[14:8], i2c_dev_addr_o);
    rd = 1;
    step(2);
    rd = 0;
    chk("i2c read refused", 0, bus_read_o);
    $display("mode test done");
    phy_reset_n_i = 0;
    step(PR + 3);
    phy_reset_n_i = 1;
    step(2);
    chk("phy ready", 1, phy_ready_o);
    phy_reset_n_i = 0;
    step(PR / 2);
    phy_reset_n_i = 1;
    step(2);
    chk("phy short", 0, phy_ready_o);
    $display("phy test done");
    ce_i = 0;
    link_up_i = 0;
    step(2);
    chk("frozen link", 0, link_led_n_o);
    ce_i = 1;
    step(1);
    chk("link after run", 1, link_led_n_o);
    $display("enable test done");
    tally_and_finish();
  end
endmodule // net_host_pins_test
